//--- core/scs_regs.v
// system-bus control and status register bank, offsets 0x0 to 0xF
// assumes a byte-wide slave port driven by the bus arbiter; inputs synchronous to clk
`timescale 1ns/1ns
`include "scs_map.vh"

// Functional notes
// - bit 0 is each register's MSB
// - all writable registers reset to zero
// - read-only identity word, leading one
// - 32-bit scratch word, no side effects
// - readback valid-byte count field
// - keepalive keeps host port, no mode resample
// - hold bit stops readback address advance
// - chain bit enables daisy-chained bitstreams
// - per-master hold bits, owner-only writes
// - reprogram flags; bit 5 forces reconfiguration
// - readback-init bit initialises readback logic
// - set/reset bit asserts global set/reset
// - two-bit configuration error code
// - init and done pad levels shown
// - bus error field, first error address
// - alarm when readback address leaves range
// - configuration write byte-count field
// - block RAM and core init failure flags
// - pending flag while readback data waits
// - handshake flag when config accepts word
module scs_regs (
    input wire clk,
    input wire rstn,
    input wire sb_req,
    input wire sb_write,
    input wire [3:0] sb_addr,
    input wire [7:0] sb_wdata,
    input wire [1:0] sb_master,
    output reg sb_ack,
    output reg [7:0] sb_rdata,
    input wire rbk_size_load,
    input wire [1:0] rbk_size_value,
    input wire rbk_addr_load,
    input wire [`SCS_RBK_AW-1:0] rbk_addr_value,
    input wire rbk_data_read,
    input wire rbk_data_waiting,
    input wire core_pgm_event,
    input wire fabric_pgm_event,
    input wire [2:0] mode_pins,
    input wire cfg_active,
    input wire cfg_start,
    input wire [1:0] cfg_err_code,
    input wire [1:0] cfg_byte_code,
    input wire cfg_word_ready,
    input wire ram_init_fail,
    input wire core_init_fail,
    input wire init_pad,
    input wire done_pad,
    input wire bus_err_event,
    input wire bus_err_invalid,
    input wire [31:0] bus_err_addr,
    output reg host_port_enable,
    output reg chain_bitstream_enable,
    output reg core_bus_hold,
    output reg fabric_bus_hold,
    output reg host_bus_hold,
    output reg reconfig_start,
    output reg [2:0] reconfig_mode,
    output reg readback_init,
    output reg global_set_reset,
    output reg [`SCS_RBK_AW-1:0] readback_address,
    output reg [31:0] bus_err_first_addr
);

    wire [31:0] scratch_word;
    reg [7:0] readback_config_ctl;
    reg [7:0] bus_hold_program_ctl;
    reg [1:0] bus_err_field;
    reg mode_taken;
    reg [7:0] next_rdata;
    wire [`SCS_RBK_AW-1:0] ptr_address;
    wire readback_range_alarm;
    wire [7:0] config_status_primary;
    wire [7:0] config_status_secondary;
    wire wr_any;
    wire hold_ptr;
    wire [1:0] bus_err_base;

    assign wr_any = sb_req && sb_write;
    assign bus_err_base = cfg_start ? `SCS_BERR_NONE : bus_err_field;
    assign hold_ptr = readback_config_ctl[`SCS_HOLD_PTR_BIT];

    // big-endian byte pick: lane 0 is bits 0:7, the most significant byte
    function [7:0] word_byte;
        input [31:0] word;
        input [1:0] lane;
        begin
            case (lane)
                2'h0: word_byte = word[31:24];
                2'h1: word_byte = word[23:16];
                2'h2: word_byte = word[15:8];
                default: word_byte = word[7:0];
            endcase
        end
    endfunction

    // address match gate, used by every write path
    function wr_hit;
        input req;
        input [3:0] addr;
        input [3:0] target;
        begin
            wr_hit = req && (addr == target);
        end
    endfunction

    // live status levels, picked up by the read mux
    assign config_status_primary = {cfg_err_code,
        init_pad,
        done_pad,
        1'b0,
        bus_err_field,
        readback_range_alarm};
    assign config_status_secondary = {cfg_byte_code,
        ram_init_fail,
        core_init_fail,
        2'b00,
        rbk_data_waiting,
        cfg_word_ready};

    scs_rbk_pointer u_rbk_pointer (
        .clk(clk),
        .rstn(rstn),
        .load(rbk_addr_load),
        .load_value(rbk_addr_value),
        .data_read(rbk_data_read),
        .hold_ptr(hold_ptr),
        .clear_alarm(readback_init),
        .address(ptr_address),
        .range_alarm(readback_range_alarm)
    );

    // scratch word, one register per byte lane so each lane has a single driver
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane = lane + 1) begin : g_scratch
            reg [7:0] lane_byte;
            always @(posedge clk) begin
                if (!rstn) begin
                    lane_byte <= `SCS_RST_BYTE;
                end else if (wr_hit(wr_any, sb_addr, `SCS_OFF_SCRATCH0 + lane[3:0])) begin
                    lane_byte <= sb_wdata;
                end
            end
            // lane 0 lands in the top byte, big-endian
            assign scratch_word[31-8*lane -: 8] = lane_byte;
        end
    endgenerate

    // readback/configuration control byte
    always @(posedge clk) begin
        if (!rstn) begin
            readback_config_ctl <= `SCS_RST_BYTE;
        end else begin
            if (wr_hit(wr_any, sb_addr, `SCS_OFF_RBK_CTL)) begin
                // reserved low bits are dropped so they always read zero
                readback_config_ctl <= sb_wdata & `SCS_RBK_WMASK;
            end
            // the readback logic's own count wins over a software write
            if (rbk_size_load) begin
                readback_config_ctl[`SCS_RBK_SIZE_HI:`SCS_RBK_SIZE_LO] <= rbk_size_value;
            end
        end
    end

    // hold and program byte
    always @(posedge clk) begin
        if (!rstn) begin
            bus_hold_program_ctl <= `SCS_RST_BYTE;
        end else begin
            if (wr_hit(wr_any, sb_addr, `SCS_OFF_HOLD_CTL)) begin
                if (sb_master == `SCS_MST_CORE) begin
                    bus_hold_program_ctl[`SCS_CORE_HOLD_BIT] <=
                        sb_wdata[`SCS_CORE_HOLD_BIT];
                end
                if (sb_master == `SCS_MST_FABRIC) begin
                    bus_hold_program_ctl[`SCS_FABRIC_HOLD_BIT] <=
                        sb_wdata[`SCS_FABRIC_HOLD_BIT];
                end
                if (sb_master == `SCS_MST_HOST) begin
                    bus_hold_program_ctl[`SCS_HOST_HOLD_BIT] <=
                        sb_wdata[`SCS_HOST_HOLD_BIT];
                end
                // program and action bits are open to every master
                bus_hold_program_ctl[`SCS_CORE_PGM_BIT:`SCS_GLOBAL_RST_BIT] <=
                    sb_wdata[`SCS_CORE_PGM_BIT:`SCS_GLOBAL_RST_BIT];
            end
            // hardware set beats a clearing write in the same cycle
            if (core_pgm_event) begin
                bus_hold_program_ctl[`SCS_CORE_PGM_BIT] <= 1'b1;
            end
            if (fabric_pgm_event) begin
                bus_hold_program_ctl[`SCS_FABRIC_PGM_BIT] <= 1'b1;
            end
        end
    end

    // bus error capture during configuration; an error in the cycle of a
    // fresh start is kept, the start only clears what came before it
    always @(posedge clk) begin
        if (!rstn) begin
            bus_err_field <= `SCS_BERR_NONE;
            bus_err_first_addr <= `SCS_RST_WORD;
        end else if (cfg_active && bus_err_event) begin
            if (bus_err_base == `SCS_BERR_NONE || bus_err_base == `SCS_BERR_INVALID) begin
                bus_err_field <= `SCS_BERR_ONE;
                if (bus_err_base == `SCS_BERR_NONE) begin
                    bus_err_first_addr <= bus_err_addr;
                end
            end else begin
                bus_err_field <= `SCS_BERR_MANY;
            end
        end else if (cfg_active && bus_err_invalid && bus_err_base == `SCS_BERR_NONE) begin
            bus_err_field <= `SCS_BERR_INVALID;
            bus_err_first_addr <= bus_err_addr;
        end else if (cfg_start) begin
            bus_err_field <= `SCS_BERR_NONE;
        end
    end

    // mode pins caught once after reset; never resampled afterwards
    always @(posedge clk) begin
        if (!rstn) begin
            mode_taken <= 1'b0;
            reconfig_mode <= 3'h0;
        end else if (!mode_taken) begin
            mode_taken <= 1'b1;
            reconfig_mode <= mode_pins;
        end
    end

    // control outputs, all registered
    always @(posedge clk) begin
        if (!rstn) begin
            host_port_enable <= 1'b1;
            chain_bitstream_enable <= 1'b0;
            core_bus_hold <= 1'b0;
            fabric_bus_hold <= 1'b0;
            host_bus_hold <= 1'b0;
            reconfig_start <= 1'b0;
            readback_init <= 1'b0;
            global_set_reset <= 1'b0;
            readback_address <= {`SCS_RBK_AW{1'b0}};
        end else begin
            // keepalive lets the host port ride through reconfiguration
            host_port_enable <= !cfg_active ||
                                readback_config_ctl[`SCS_KEEPALIVE_BIT];
            chain_bitstream_enable <= readback_config_ctl[`SCS_CHAIN_BIT];
            core_bus_hold <= bus_hold_program_ctl[`SCS_CORE_HOLD_BIT];
            fabric_bus_hold <= bus_hold_program_ctl[`SCS_FABRIC_HOLD_BIT];
            host_bus_hold <= bus_hold_program_ctl[`SCS_HOST_HOLD_BIT];
            // one pulse per write of a one
            reconfig_start <= wr_hit(wr_any, sb_addr, `SCS_OFF_HOLD_CTL) &&
                              sb_wdata[`SCS_HOST_PGM_BIT];
            readback_init <= wr_hit(wr_any, sb_addr, `SCS_OFF_HOLD_CTL) &&
                             sb_wdata[`SCS_RBK_INIT_BIT];
            global_set_reset <= bus_hold_program_ctl[`SCS_GLOBAL_RST_BIT];
            readback_address <= ptr_address;
        end
    end

    // read decode
    always @* begin
        next_rdata = 8'h00;
        if (sb_addr <= `SCS_OFF_IDENT3) begin
            next_rdata = word_byte(`SCS_IDENT_WORD, sb_addr[1:0]);
        end else if (sb_addr <= `SCS_OFF_SCRATCH3) begin
            next_rdata = word_byte(scratch_word, sb_addr[1:0]);
        end else if (sb_addr == `SCS_OFF_RBK_CTL) begin
            next_rdata = readback_config_ctl;
        end else if (sb_addr == `SCS_OFF_HOLD_CTL) begin
            next_rdata = bus_hold_program_ctl;
        end else if (sb_addr == `SCS_OFF_STAT_A) begin
            next_rdata = config_status_primary;
        end else if (sb_addr == `SCS_OFF_STAT_B) begin
            next_rdata = config_status_secondary;
        end
    end

    // answer one cycle after each request; read data holds until the next read
    always @(posedge clk) begin
        if (!rstn) begin
            sb_ack <= 1'b0;
            sb_rdata <= 8'h00;
        end else begin
            sb_ack <= sb_req;
            if (sb_req && !sb_write) begin
                sb_rdata <= next_rdata;
            end
        end
    end

endmodule

//--- core/scs_map.vh
// constants for the system-bus control/status register bank
// assumes byte-wide register accesses, bit 0 of each register is its MSB
`ifndef SCS_MAP_VH
`define SCS_MAP_VH

// byte offsets inside the bank
`define SCS_OFF_IDENT0 4'h0
`define SCS_OFF_IDENT3 4'h3
`define SCS_OFF_SCRATCH0 4'h4
`define SCS_OFF_SCRATCH3 4'h7
`define SCS_OFF_RBK_CTL 4'h8
`define SCS_OFF_HOLD_CTL 4'h9
`define SCS_OFF_STAT_A 4'hC
`define SCS_OFF_STAT_B 4'hD

// identity word, value arbitrary; MSB fixed at one
`define SCS_IDENT_WORD 32'h8F0A5123

// reset values
`define SCS_RST_BYTE 8'h00
`define SCS_RST_WORD 32'h00000000

// field positions in [7:0] numbering (big-endian bit n sits at 7-n)
`define SCS_RBK_SIZE_HI 7
`define SCS_RBK_SIZE_LO 6
`define SCS_KEEPALIVE_BIT 5
`define SCS_HOLD_PTR_BIT 4
`define SCS_CHAIN_BIT 3
`define SCS_RBK_WMASK 8'hF8
`define SCS_CORE_HOLD_BIT 7
`define SCS_FABRIC_HOLD_BIT 6
`define SCS_HOST_HOLD_BIT 5
`define SCS_CORE_PGM_BIT 4
`define SCS_FABRIC_PGM_BIT 3
`define SCS_HOST_PGM_BIT 2
`define SCS_RBK_INIT_BIT 1
`define SCS_GLOBAL_RST_BIT 0

// bus master identities
`define SCS_MST_CORE 2'h0
`define SCS_MST_FABRIC 2'h1
`define SCS_MST_HOST 2'h2

// bus error field codes
`define SCS_BERR_NONE 2'h0
`define SCS_BERR_INVALID 2'h1
`define SCS_BERR_ONE 2'h2
`define SCS_BERR_MANY 2'h3

// readback address
`define SCS_RBK_AW 14
`define SCS_RBK_LIMIT 14'h3FFF

`endif

//--- core/scs_rbk_pointer.v
// readback address pointer with hold and range alarm
// assumes load and read strobes are one-cycle pulses on clk
`timescale 1ns/1ns
`include "scs_map.vh"

module scs_rbk_pointer (
    input wire clk,
    input wire rstn,
    input wire load,
    input wire [`SCS_RBK_AW-1:0] load_value,
    input wire data_read,
    input wire hold_ptr,
    input wire clear_alarm,
    output reg [`SCS_RBK_AW-1:0] address,
    output reg range_alarm
);

    always @(posedge clk) begin
        if (!rstn) begin
            address <= {`SCS_RBK_AW{1'b0}};
            range_alarm <= 1'b0;
        end else begin
            if (load) begin
                address <= load_value;
            end else if (data_read && !hold_ptr) begin
                address <= address + {{(`SCS_RBK_AW-1){1'b0}}, 1'b1};
            end
            // stepping past the top wraps the pointer; the alarm keeps it known
            if (data_read && !hold_ptr && !load && address == `SCS_RBK_LIMIT) begin
                range_alarm <= 1'b1;
            end else if (clear_alarm) begin
                range_alarm <= 1'b0;
            end
        end
    end

endmodule

//--- sim/scs_regs_sva.sv
// timing and cause checks for the control/status register bank
// assumes byte requests are single-cycle pulses and outputs settle one clock after a write lands
`timescale 1ns/1ns
`include "scs_map.vh"
module scs_regs_sva (
    input wire clk,
    input wire rstn,
    input wire sb_req,
    input wire sb_write,
    input wire [3:0] sb_addr,
    input wire [7:0] sb_wdata,
    input wire [1:0] sb_master,
    input wire sb_ack,
    input wire [7:0] sb_rdata,
    input wire cfg_active,
    input wire cfg_word_ready,
    input wire host_port_enable,
    input wire chain_bitstream_enable,
    input wire host_bus_hold,
    input wire reconfig_start,
    input wire readback_init,
    input wire global_set_reset
);
    localparam logic [31:0] ID = `SCS_IDENT_WORD;
    wire rd = sb_req && !sb_write;
    wire w9 = sb_req && sb_write && sb_addr == 4'h9;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    unused_read_zero_a: assert property (
        rd && sb_addr inside {4'hA, 4'hB, 4'hE, 4'hF} |=> sb_ack && sb_rdata == 8'h00)
        else $error("unused offset read not zero");
    ident_msb_a: assert property (rd && sb_addr == 4'h0 |=> sb_rdata == ID[31:24])
        else $error("identity byte wrong");
    chain_follow_a: assert property (
        sb_req && sb_write && sb_addr == 4'h8 |=> ##1 chain_bitstream_enable == $past(sb_wdata[3], 2))
        else $error("chain enable not following write");
    global_reset_a: assert property (
        w9 |=> ##1 global_set_reset == $past(sb_wdata[0], 2))
        else $error("set/reset level not following write");
    reconfig_cause_a: assert property (reconfig_start |-> $past(w9 && sb_wdata[2]))
        else $error("reconfiguration pulse without request");
    rbk_init_cause_a: assert property (readback_init |-> $past(w9 && sb_wdata[1]))
        else $error("readback init pulse without request");
    host_hold_owner_a: assert property (
        $rose(host_bus_hold) |-> $past(w9 && sb_master == 2'h2, 2))
        else $error("host hold set by another master");
    keepalive_a: assert property (!$past(cfg_active) |-> host_port_enable)
        else $error("host port dropped outside configuration");
    ready_live_a: assert property (
        rd && sb_addr == 4'hD && $stable(cfg_word_ready) |=> sb_rdata[0] == $past(cfg_word_ready))
        else $error("handshake flag not shown");
endmodule

bind scs_regs scs_regs_sva u_scs_regs_sva (.clk, .rstn, .sb_req, .sb_write, .sb_addr,
    .sb_wdata, .sb_master, .sb_ack, .sb_rdata, .cfg_active, .cfg_word_ready,
    .host_port_enable, .chain_bitstream_enable, .host_bus_hold, .reconfig_start,
    .readback_init, .global_set_reset);

//--- sim/scs_bus_model.sv
// system bus master model: one byte access per call, issued at a falling edge
// assumes the slave answers with a one-cycle acknowledge a clock after the request
`timescale 1ns/1ns
module scs_bus_model (
    input wire clk,
    output logic sb_req = 0,
    output logic sb_write = 0,
    output logic [3:0] sb_addr = 4'h0,
    output logic [7:0] sb_wdata = 8'h00,
    output logic [1:0] sb_master = 2'h0,
    input wire sb_ack,
    input wire [7:0] sb_rdata
);
    task xfer(input logic [1:0] m, input logic w, input logic [3:0] a, input logic [7:0] d,
              output logic [7:0] r, output logic ok);
        ok = 0;
        r = 8'h00;
        sb_master = m;
        sb_write = w;
        sb_addr = a;
        sb_wdata = (a == 4'h8) ? (d & 8'hF8) : d;
        sb_req = 1;
        // one-cycle request; the answer stands in the cycle after it is taken
        for (int i = 0; i < 4 && !ok; i++) begin
            @(negedge clk);
            sb_req = 0;
            if (sb_ack === 1'b1) begin
                ok = 1;
                r = sb_rdata;
            end
        end
        // stale write data must not look valid
        sb_wdata = ~sb_wdata;
    endtask
endmodule

//--- sim/tb_top.sv
// self-checking bench for the control/status register bank
// assumes the bus model drives the slave port; other inputs change at the falling edge
`timescale 1ns/1ns
`include "scs_map.vh"
module tb_top;
    localparam logic [31:0] ID = `SCS_IDENT_WORD;
    logic clk = 0;
    logic rstn = 0;
    wire sb_req, sb_write, sb_ack, hpe, chain, rcs, rbi, gset;
    wire [3:0] sb_addr;
    wire [7:0] sb_wdata, sb_rdata;
    wire [1:0] sb_master;
    wire [2:0] hh, rmode;
    wire [13:0] rba;
    wire [31:0] bea;
    logic [7:0] pv = 8'h00;
    logic [9:0] st = 10'h000;
    logic [31:0] eaddr = 32'h00000000;
    logic cfg_active = 0;
    logic [7:0] rd;
    logic [3:0] n_rcs = 4'h0, n_rbi = 4'h0;
    int bad_count = 0;
    int total_checks = 0;
    logic [25:0] rows [4] = '{{10'h1AC, 8'h60, 8'h91}, {10'h253, 8'h90, 8'h62},
        {10'h3FF, 8'hF0, 8'hF3}, {10'h000, 8'h00, 8'h00}};
    always #4 clk = ~clk;
    always @(negedge clk) begin
        if (rstn) begin
            n_rcs += rcs;
            n_rbi += rbi;
        end
    end
    scs_bus_model u_scs_bus_model (.clk, .sb_req, .sb_write, .sb_addr, .sb_wdata,
        .sb_master, .sb_ack, .sb_rdata);
    scs_regs u_scs_regs (.clk, .rstn, .sb_req, .sb_write, .sb_addr, .sb_wdata, .sb_master,
        .sb_ack, .sb_rdata, .rbk_size_load(pv[7]), .rbk_size_value(2'h3),
        .rbk_addr_load(pv[6]), .rbk_addr_value(14'h3FFE), .rbk_data_read(pv[5]),
        .rbk_data_waiting(st[0]), .core_pgm_event(pv[4]), .fabric_pgm_event(pv[3]),
        .mode_pins(3'h5), .cfg_active, .cfg_start(pv[2]), .cfg_err_code(st[9:8]),
        .cfg_byte_code(st[7:6]), .cfg_word_ready(st[5]), .ram_init_fail(st[4]),
        .core_init_fail(st[3]), .init_pad(st[2]), .done_pad(st[1]),
        .bus_err_event(pv[1]), .bus_err_invalid(pv[0]), .bus_err_addr(eaddr),
        .host_port_enable(hpe), .chain_bitstream_enable(chain), .core_bus_hold(hh[2]),
        .fabric_bus_hold(hh[1]), .host_bus_hold(hh[0]), .reconfig_start(rcs),
        .reconfig_mode(rmode), .readback_init(rbi), .global_set_reset(gset),
        .readback_address(rba), .bus_err_first_addr(bea));
    task check(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task stop_test;
        if (bad_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task acc(input logic [1:0] m, input logic w, input logic [3:0] a, input logic [7:0] d);
        logic ok;
        u_scs_bus_model.xfer(m, w, a, d, rd, ok);
        if (ok !== 1'b1) begin
            bad_count++;
            stop_test;
        end
        @(negedge clk);
    endtask
    task rdc(input logic [3:0] a, input logic [7:0] e);
        acc(2'h2, 0, a, 8'h00);
        check(rd, e);
    endtask
    // one-cycle strobes on the side inputs, then one more cycle for the outputs
    task pulse(input logic [7:0] m);
        pv = m;
        @(negedge clk) pv = 8'h00;
        @(negedge clk);
    endtask
    initial begin
        repeat (20) @(negedge clk);
        rstn = 1;
        check({hpe, chain, hh, rcs, rbi, gset, rba}, {1'b1, 21'h0});
        foreach (rows[i]) begin
            st = rows[i][25:16];
            @(negedge clk);
            rdc(4'hC, rows[i][15:8]);
            rdc(4'hD, rows[i][7:0]);
        end
        st = 10'h000;
        check(rmode, 3'h5);
        for (int a = 0; a < 16; a++)
            rdc(a[3:0], a < 4 ? ID[31 - 8 * a -: 8] : 8'h00);
        acc(2'h2, 1, 4'h0, 8'h00);
        rdc(4'h0, ID[31:24]);
        for (int a = 4; a < 8; a++)
            acc(2'h1, 1, a[3:0], 8'h3C ^ a[7:0]);
        for (int a = 4; a < 8; a++)
            rdc(a[3:0], 8'h3C ^ a[7:0]);
        acc(2'h2, 1, 4'h8, 8'h08);
        cfg_active = 1;
        repeat (2) @(negedge clk);
        check(hpe, 1'b0);
        acc(2'h2, 1, 4'h8, 8'h38);
        check({hpe, chain}, 2'h3);
        rdc(4'h8, 8'h38);
        pulse(8'h80);
        rdc(4'h8, 8'hF8);
        pulse(8'h40);
        pulse(8'h20);
        check(rba, 14'h3FFE);
        acc(2'h2, 1, 4'h8, 8'h08);
        pulse(8'h20);
        check(rba, 14'h3FFF);
        pulse(8'h20);
        check(rba, 14'h0000);
        rdc(4'hC, 8'h01);
        acc(2'h2, 1, 4'h9, 8'h02);
        rdc(4'hC, 8'h00);
        eaddr = 32'h00001234;
        pulse(8'h02);
        rdc(4'hC, 8'h04);
        eaddr = 32'h00005678;
        pulse(8'h02);
        rdc(4'hC, 8'h06);
        check(bea, 32'h00001234);
        pulse(8'h04);
        pulse(8'h01);
        rdc(4'hC, 8'h02);
        check(bea, 32'h00005678);
        // a fresh start and an error in one cycle: the error is kept
        eaddr = 32'h00009ABC;
        pulse(8'h06);
        rdc(4'hC, 8'h04);
        check(bea, 32'h00009ABC);
        acc(2'h2, 1, 4'h9, 8'h20);
        acc(2'h1, 1, 4'h9, 8'h40);
        acc(2'h0, 1, 4'h9, 8'hE0);
        rdc(4'h9, 8'hE0);
        acc(2'h1, 1, 4'h9, 8'h00);
        check(hh, 3'h5);
        pulse(8'h18);
        rdc(4'h9, 8'hB8);
        acc(2'h0, 1, 4'h9, 8'h84);
        acc(2'h0, 1, 4'h9, 8'h81);
        check(gset, 1'b1);
        check({n_rcs, n_rbi}, 8'h11);
        rstn = 0;
        repeat (2) @(negedge clk);
        rstn = 1;
        check({hpe, chain, hh, rcs, rbi, gset, rba}, {1'b1, 21'h0});
        rdc(4'h4, 8'h00);
        stop_test;
    end
endmodule
